// >>> mfp_cfg.svh
// Register offsets, field positions, reset values and timing counts for the multifunction pin block
`ifndef MFP_CFG_SVH
`define MFP_CFG_SVH
`define MFP_ADDR_COMPARATOR_PROTECT_STATUS 8'h23
`define MFP_ADDR_PIN_CONFIG 8'h24
`define MFP_COMPARATOR_PROTECT_STATUS_RST 16'h000C
`define MFP_PIN_CONFIG_RST 16'h0000
`define MFP_BIT_PROTECT 8
`define MFP_BIT_WINDOW 7
`define MFP_BIT_SYNC 3
`define MFP_BIT_FILTER_EN 15
`define MFP_BIT_OUT_EN 13
`define MFP_OSEL_HI 12
`define MFP_OSEL_LO 9
`define MFP_CSEL_HI 8
`define MFP_CSEL_LO 5
`define MFP_IFUN_HI 4
`define MFP_IFUN_LO 1
`define MFP_BIT_IN_EN 0
`define MFP_CFG_WMASK 16'hBFFF
`define MFP_FILTER_NS 200
`define MFP_CLK_NS 40
`define MFP_FILTER_CYC ((`MFP_FILTER_NS + `MFP_CLK_NS - 1) / `MFP_CLK_NS)
`endif

// >>> mfp_pkg.sv
// Types shared by the multifunction pin block
package mfp_pkg;
  typedef enum logic [3:0] {
    MFP_IN_SLEEP = 4'h0,
    MFP_IN_FAULT = 4'h2,
    MFP_IN_POWER = 4'h4,
    MFP_IN_PROTECT = 4'h5,
    MFP_IN_CLEAR = 4'h7,
    MFP_IN_LOAD = 4'h8,
    MFP_IN_WAVE = 4'h9,
    MFP_IN_MARGIN = 4'hA,
    MFP_IN_RESET = 4'hB,
    MFP_IN_NVMWP = 4'hC,
    MFP_IN_LOCK = 4'hD
  } mfp_in_func_t;
  typedef enum logic [3:0] {
    MFP_OUT_MEM = 4'h1,
    MFP_OUT_CH2 = 4'h4,
    MFP_OUT_CH0 = 4'h6,
    MFP_OUT_CH1 = 4'h7,
    MFP_OUT_WIN = 4'hB
  } mfp_out_sel_t;
endpackage

// >>> mfp_glitch_filter.sv
// Glitch filter for the pin input: a level must hold for a set count before it passes
`timescale 1ns/1ps
`include "mfp_cfg.svh"
module mfp_glitch_filter import mfp_pkg::*; #(
  parameter int STABLE_CYC = `MFP_FILTER_CYC
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic din,
  output logic dout
);
  localparam int CW = $clog2(STABLE_CYC + 1);
  // Elaboration guard: a zero count would leave the compare below unreachable
  if (STABLE_CYC < 1) begin : g_bad_stable_cyc
    $error("STABLE_CYC must be at least 1");
  end
  typedef struct packed {
    logic out;
    logic [CW-1:0] cnt;
  } mfp_filt_state_t;
  mfp_filt_state_t st_reg;
  mfp_filt_state_t st_next;
  // Count samples that differ from the output; a short pulse restarts the count and is dropped
  always_comb begin
    st_next = st_reg;
    if (din == st_reg.out) begin
      st_next.cnt = '0;
    end else if (st_reg.cnt == CW'(STABLE_CYC - 1)) begin
      st_next.out = din;
      st_next.cnt = '0;
    end else begin
      st_next.cnt = st_reg.cnt + CW'(1);
    end
  end
  // Resting level is high, matching an idle pulled-up pin
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_reg <= '{out: 1'b1, cnt: '0};
    end else if (ce) begin
      st_reg <= st_next;
    end
  end
  assign dout = st_reg.out;
endmodule

// >>> mfp_pin_ctrl.sv
// Multifunction pin configuration, pin actions and comparator/protect status
`timescale 1ns/1ps
`include "mfp_cfg.svh"
module mfp_pin_ctrl import mfp_pkg::*; #(
  parameter int FILTER_CYC = `MFP_FILTER_CYC
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  // Multifunction pin
  input wire logic multifunction_pin_in,
  output logic multifunction_pin_out,
  output logic multifunction_pin_oe,
  // Internal status sources
  input wire logic memory_busy_flag,
  input wire logic ch0_busy,
  input wire logic ch1_busy,
  input wire logic ch2_busy,
  input wire logic window_compare_raw,
  input wire logic window_latch_enable,
  input wire logic compare_raw_ch1,
  input wire logic protect_active,
  // Global actions
  output logic deep_sleep,
  output logic fault_dump_pulse,
  output logic protect_start_pulse,
  output logic clear_input_n,
  output logic device_reset,
  output logic nvm_write_allowed,
  output logic register_lock,
  // Per-channel actions, index 0..2 is channel 0..2
  output logic [2:0] channel_powerdown_load,
  output logic [2:0] load_update_input,
  output logic [2:0] wave_run,
  output logic [2:0] margin_high,
  output logic [2:0] margin_pulse
);
  // Elaboration guard: the filter needs at least one stable sample
  if (FILTER_CYC < 1) begin : g_bad_filter_cyc
    $error("FILTER_CYC must be at least 1");
  end

  typedef struct packed {
    logic [15:0] cfg;
    logic protect_flag;
    logic window_hold;
    logic cmp_s1;
    logic cmp_s2;
    logic pin_s1;
    logic pin_s2;
    logic pin_prev;
    logic [15:0] rdata;
    logic pin_out;
    logic sleep;
    logic fault;
    logic prot;
    logic clr_n;
    logic rst;
    logic nvm_ok;
    logic lock;
    logic [2:0] pdn;
    logic [2:0] load;
    logic [2:0] run;
    logic [2:0] mhigh;
    logic [2:0] mpulse;
  } mfp_state_t;

  mfp_state_t st_reg;
  mfp_state_t st_next;
  logic filt_pin;
  logic pin_used;
  logic fall;
  logic rise;
  logic [2:0] chan_en;
  logic [3:0] csel;
  mfp_in_func_t ifun;
  logic win_bit;

  // Filter always runs on the synchronized pin so switching modes sees a settled level
  mfp_glitch_filter #(
    .STABLE_CYC(FILTER_CYC)
  ) u_filter (
    .clk(clk),
    .rst_b(rst_b),
    .ce(ce),
    .din(st_reg.pin_s2),
    .dout(filt_pin)
  );

  // Input path selection and edge decode
  always_comb begin
    pin_used = st_reg.cfg[`MFP_BIT_FILTER_EN] ? filt_pin : st_reg.pin_s2;
    fall = st_reg.pin_prev & ~pin_used;
    rise = ~st_reg.pin_prev & pin_used;
    csel = st_reg.cfg[`MFP_CSEL_HI:`MFP_CSEL_LO];
    chan_en = {csel[0], csel[3], csel[2]}; // bit i is channel i
    ifun = mfp_in_func_t'(st_reg.cfg[`MFP_IFUN_HI:`MFP_IFUN_LO]);
    win_bit = window_latch_enable ? st_reg.window_hold : window_compare_raw;
  end

  // Next state: registers, status, pin actions
  always_comb begin
    st_next = st_reg;
    st_next.fault = 1'b0;
    st_next.prot = 1'b0;
    st_next.load = 3'h0;
    st_next.mpulse = 3'h0;
    // Two-flop synchronizers; the first stage feeds only the second
    st_next.cmp_s1 = compare_raw_ch1;
    st_next.cmp_s2 = st_reg.cmp_s1;
    st_next.pin_s1 = multifunction_pin_in;
    st_next.pin_s2 = st_reg.pin_s1;
    st_next.pin_prev = pin_used;
    // Latched window result holds a trip until latch mode is left
    if (!window_latch_enable) begin
      st_next.window_hold = 1'b0;
    end else if (window_compare_raw) begin
      st_next.window_hold = 1'b1;
    end
    // Register read data, captured for the next cycle
    st_next.rdata = 16'h0000;
    if (reg_rd) begin
      if (reg_addr == `MFP_ADDR_COMPARATOR_PROTECT_STATUS) begin
        st_next.rdata = `MFP_COMPARATOR_PROTECT_STATUS_RST & 16'h0004;
        st_next.rdata[`MFP_BIT_PROTECT] = st_reg.protect_flag;
        st_next.rdata[`MFP_BIT_WINDOW] = win_bit;
        st_next.rdata[`MFP_BIT_SYNC] = st_reg.cmp_s2;
      end else if (reg_addr == `MFP_ADDR_PIN_CONFIG) begin
        st_next.rdata = st_reg.cfg;
      end
    end
    // Read clears the protect flag, but a protect event in the same cycle wins
    if (reg_rd && reg_addr == `MFP_ADDR_COMPARATOR_PROTECT_STATUS) begin
      st_next.protect_flag = 1'b0;
    end
    if (protect_active || st_reg.prot) begin
      st_next.protect_flag = 1'b1;
    end
    // Configuration write; bit 14 is don't-care and stays zero
    if (reg_wr && reg_addr == `MFP_ADDR_PIN_CONFIG) begin
      st_next.cfg = reg_wdata & `MFP_CFG_WMASK;
    end
    // Output routing; unlisted codes drive low
    unique case (st_reg.cfg[`MFP_OSEL_HI:`MFP_OSEL_LO])
      MFP_OUT_MEM: st_next.pin_out = memory_busy_flag;
      MFP_OUT_CH2: st_next.pin_out = ch2_busy;
      MFP_OUT_CH0: st_next.pin_out = ch0_busy;
      MFP_OUT_CH1: st_next.pin_out = ch1_busy;
      MFP_OUT_WIN: st_next.pin_out = win_bit;
      default: st_next.pin_out = 1'b0;
    endcase
    // Clear follows the level and releases as soon as input mode or code changes
    st_next.clr_n = 1'b1;
    if (st_reg.cfg[`MFP_BIT_IN_EN] && ifun == MFP_IN_CLEAR) begin
      st_next.clr_n = pin_used;
    end
    // Edge actions, only while input mode is on
    if (st_reg.cfg[`MFP_BIT_IN_EN]) begin
      unique case (ifun)
        MFP_IN_SLEEP: begin
          if (fall) st_next.sleep = 1'b1;
          if (rise) st_next.sleep = 1'b0;
        end
        MFP_IN_FAULT: st_next.fault = fall;
        MFP_IN_POWER: begin
          if (fall) st_next.pdn = st_reg.pdn | chan_en;
          if (rise) st_next.pdn = st_reg.pdn & ~chan_en;
        end
        MFP_IN_PROTECT: st_next.prot = fall;
        MFP_IN_CLEAR: st_next.fault = 1'b0;
        MFP_IN_LOAD: begin
          if (fall) st_next.load = chan_en;
        end
        MFP_IN_WAVE: begin
          if (fall) st_next.run = st_reg.run & ~chan_en;
          if (rise) st_next.run = st_reg.run | chan_en;
        end
        MFP_IN_MARGIN: begin
          if (fall) begin
            st_next.mhigh = st_reg.mhigh & ~chan_en;
            st_next.mpulse = chan_en;
          end
          if (rise) begin
            st_next.mhigh = st_reg.mhigh | chan_en;
            st_next.mpulse = chan_en;
          end
        end
        MFP_IN_RESET: begin
          if (fall) st_next.rst = 1'b1;
          if (rise) st_next.rst = 1'b0;
        end
        MFP_IN_NVMWP: begin
          if (fall) st_next.nvm_ok = 1'b1;
          if (rise) st_next.nvm_ok = 1'b0;
        end
        MFP_IN_LOCK: begin
          if (fall) st_next.lock = 1'b0;
          if (rise) st_next.lock = 1'b1;
        end
        default: st_next.fault = 1'b0;
      endcase
    end
    // Leaving reset mode drops the held reset so the device cannot stay stuck
    if (!(st_reg.cfg[`MFP_BIT_IN_EN] && ifun == MFP_IN_RESET)) begin
      st_next.rst = 1'b0;
    end
    // The held device reset clears the volatile configuration itself
    if (st_reg.rst) begin
      st_next.cfg = `MFP_PIN_CONFIG_RST;
    end
  end

  // Single state register; comparator sync resets to one, pin history to high
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_reg <= '0;
      st_reg.cfg <= `MFP_PIN_CONFIG_RST;
      st_reg.cmp_s1 <= 1'b1;
      st_reg.cmp_s2 <= 1'b1;
      st_reg.pin_s1 <= 1'b1;
      st_reg.pin_s2 <= 1'b1;
      st_reg.pin_prev <= 1'b1;
      st_reg.clr_n <= 1'b1;
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  // Outputs, all from flip-flops, the drive enable straight from config bit 13
  assign reg_rdata = st_reg.rdata;
  assign multifunction_pin_out = st_reg.pin_out;
  assign multifunction_pin_oe = st_reg.cfg[`MFP_BIT_OUT_EN];
  assign deep_sleep = st_reg.sleep;
  assign fault_dump_pulse = st_reg.fault;
  assign protect_start_pulse = st_reg.prot;
  assign clear_input_n = st_reg.clr_n;
  assign device_reset = st_reg.rst;
  assign nvm_write_allowed = st_reg.nvm_ok;
  assign register_lock = st_reg.lock;
  assign channel_powerdown_load = st_reg.pdn;
  assign load_update_input = st_reg.load;
  assign wave_run = st_reg.run;
  assign margin_high = st_reg.mhigh;
  assign margin_pulse = st_reg.mpulse;
endmodule

// >>> mfp_pin_ctrl_properties.sv
// Concurrent checks on the multifunction pin block ports
`timescale 1ns/1ps
module mfp_pin_ctrl_properties (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic [7:0] reg_addr,
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  input wire logic multifunction_pin_in,
  input wire logic multifunction_pin_oe,
  input wire logic compare_raw_ch1,
  input wire logic protect_active,
  input wire logic deep_sleep,
  input wire logic fault_dump_pulse,
  input wire logic protect_start_pulse,
  input wire logic clear_input_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // Status read, config write and a cycle with no protect source
  sequence s_rd_st;
    ce && reg_rd && reg_addr == 8'h23;
  endsequence
  sequence s_wr_cfg;
    ce && reg_wr && reg_addr == 8'h24;
  endsequence
  sequence s_quiet;
    ce && !protect_active && !protect_start_pulse;
  endsequence
  AST_OE: assert property (s_wr_cfg |=> multifunction_pin_oe == $past(reg_wdata[13]))
    else $error("pin drive enable does not follow config");
  AST_PFLAG_SET: assert property (ce && protect_active ##1 s_rd_st |=> reg_rdata[8])
    else $error("protect flag not set");
  // Second read two cycles on, with no source in between, must see the flag gone
  AST_PFLAG_CLR: assert property ((s_rd_st ##0 s_quiet) ##1 s_quiet ##1 s_rd_st
    |=> !reg_rdata[8])
    else $error("protect flag not cleared by read");
  AST_SYNC: assert property ((ce && $stable(compare_raw_ch1)) [*4] ##0 s_rd_st
    |=> reg_rdata[3] == $past(compare_raw_ch1))
    else $error("sync compare bit wrong");
  AST_FAULT_ONE: assert property ($rose(fault_dump_pulse) |=> !fault_dump_pulse)
    else $error("fault dump pulse too long");
  AST_PROT_ONE: assert property (protect_start_pulse |=> !protect_start_pulse)
    else $error("protect start pulse too long");
  // Two sync stages and the action flop put the causing pin sample three edges back
  AST_SLEEP: assert property ($rose(deep_sleep) |-> $past(multifunction_pin_in, 3) == 1'b0)
    else $error("sleep without low pin");
  AST_CLEAR: assert property ($fell(clear_input_n) |-> !$past(multifunction_pin_in, 3))
    else $error("clear without low pin");
endmodule
bind mfp_pin_ctrl mfp_pin_ctrl_properties u_mfp_pin_ctrl_properties (.clk, .rst_b, .ce,
  .reg_addr, .reg_rd, .reg_wr, .reg_wdata, .reg_rdata, .multifunction_pin_in,
  .multifunction_pin_oe, .compare_raw_ch1, .protect_active, .deep_sleep, .fault_dump_pulse,
  .protect_start_pulse, .clear_input_n);

// >>> mfp_host_model.sv
// Host controller model on the multifunction pin
`timescale 1ns/1ps
module mfp_host_model (
  input wire logic host_drive,
  input wire logic host_level,
  input wire logic multifunction_pin_out,
  input wire logic multifunction_pin_oe,
  output logic pin_level
);
  // Device driver wins; a released line rises through its pull-up
  assign pin_level = multifunction_pin_oe ? multifunction_pin_out :
    (host_drive ? host_level : 1'b1);
endmodule

// >>> mfp_pin_ctrl_tb.sv
// Self-checking bench for the multifunction pin block
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin bad_count++; \
  $display("wrong value at %0t: %h vs %h", $time, a, b); end end
module mfp_pin_ctrl_tb;
  logic clk = 0, rst_b = 0, ce = 1, reg_wr = 0, reg_rd = 0, hd = 0, hl = 1;
  logic mem_b = 0, b0 = 0, b1 = 0, b2 = 0, win = 0, wle = 0, cmp = 1, pact = 0, filt;
  logic [7:0] reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata, rd, d;
  logic pin_in, pin_out, pin_oe, sleep, fault, pstart, clr_n, dev_rst, nvm_ok, lock;
  logic s_f = 0, s_p = 0, s_r = 0;
  logic [2:0] pdn, ldu, wave, mhi, mpul, m, s_ld = 0, s_mp = 0;
  logic [3:0] csel, sel;
  logic [43:0] e;
  logic [3:0] codes [12] = '{4'h0, 4'h2, 4'h3, 4'h4, 4'h5, 4'h7, 4'h8, 4'h9, 4'hA, 4'hC, 4'hB, 4'hD};
  logic [3:0] osel [6] = '{4'h1, 4'h4, 4'h6, 4'h7, 4'hB, 4'h3};
  int bad_count = 0, tests_run = 0;
  wire [21:0] obs = {sleep, s_f, s_p, ~clr_n, s_r, nvm_ok, lock, pdn, s_ld, wave, mhi, s_mp};
  mfp_pin_ctrl #(.FILTER_CYC(2)) u_mfp_pin_ctrl (.clk(clk), .rst_b(rst_b), .ce(ce),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .multifunction_pin_in(pin_in), .multifunction_pin_out(pin_out),
    .multifunction_pin_oe(pin_oe), .memory_busy_flag(mem_b), .ch0_busy(b0), .ch1_busy(b1),
    .ch2_busy(b2), .window_compare_raw(win), .window_latch_enable(wle),
    .compare_raw_ch1(cmp), .protect_active(pact), .deep_sleep(sleep),
    .fault_dump_pulse(fault), .protect_start_pulse(pstart), .clear_input_n(clr_n),
    .device_reset(dev_rst), .nvm_write_allowed(nvm_ok), .register_lock(lock),
    .channel_powerdown_load(pdn), .load_update_input(ldu), .wave_run(wave),
    .margin_high(mhi), .margin_pulse(mpul));
  mfp_host_model u_mfp_host_model (.host_drive(hd), .host_level(hl),
    .multifunction_pin_out(pin_out), .multifunction_pin_oe(pin_oe), .pin_level(pin_in));
  initial forever #20 clk = ~clk;
  // Pulses are short, so they are caught in sticky copies between checks
  always @(posedge clk) begin
    s_f <= s_f | fault;
    s_p <= s_p | pstart;
    s_r <= s_r | dev_rst;
    s_ld <= s_ld | ldu;
    s_mp <= s_mp | mpul;
  end
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rdr(input logic [7:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 rd = reg_rdata;
  endtask
  // Host moves the pin, then sticky copies restart before the action can land
  task automatic drive(input logic lv, input int n);
    @(posedge clk);
    hd <= 1'b1;
    hl <= lv;
    #2 {s_f, s_p, s_r, s_ld, s_mp} = '0;
    repeat (n) @(posedge clk);
  endtask
  // Relevant bits and expected values of obs after a fall (f=1) or a rise
  function automatic logic [43:0] expect_obs(input logic [3:0] c, input logic [2:0] k,
    input logic f);
    logic [21:0] r;
    logic [21:0] v;
    r = 22'h1A0E07;
    v = '0;
    case (c)
      4'h0: begin r[21] = 1'b1; v[21] = f; end
      4'h2: v[20] = f;
      4'h4: begin r[14:12] = 3'b111; v[14:12] = f ? k : 3'b000; end
      4'h5: v[19] = f;
      4'h7: begin r[18] = 1'b1; v[18] = f; end
      4'h8: v[11:9] = f ? k : 3'b000;
      4'h9: begin r[8:6] = 3'b111; v[8:6] = f ? 3'b000 : k; end
      4'hA: begin r[5:3] = 3'b111; v[5:3] = f ? 3'b000 : k; v[2:0] = k; end
      4'hB: v[17] = f;
      4'hC: begin r[16] = 1'b1; v[16] = f; end
      4'hD: begin r[15] = 1'b1; v[15] = !f; end
      default: ;
    endcase
    return {r, v};
  endfunction
  function automatic logic exp_out(input logic [3:0] s);
    case (s)
      4'h1: return mem_b;
      4'h4: return b2;
      4'h6: return b0;
      4'h7: return b1;
      4'hB: return win;
      default: return 1'b0;
    endcase
  endfunction
  task automatic results;
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    results();
  end
  initial begin
    void'($urandom(32'h7BB0A3D6));
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    rdr(8'h23);
    `CHK(rd, 16'h000C)
    rdr(8'h24);
    `CHK(rd, 16'h0000)
    rdr(8'h40);
    `CHK(rd, 16'h0000)
    repeat (4) begin
      d = $urandom & 16'hDFFF;
      wr(8'h24, d);
      rdr(8'h24);
      `CHK(rd, d & 16'hBFFF)
    end
    foreach (osel[i]) begin
      {mem_b, b0, b1, b2, win} <= 5'($urandom);
      wr(8'h24, {3'b001, osel[i], 9'h000});
      repeat (3) @(posedge clk);
      `CHK(pin_oe, 1'b1)
      `CHK(pin_out, exp_out(osel[i]))
      rdr(8'h23);
      `CHK(rd[7], win)
    end
    wr(8'h24, 16'h0000);
    repeat (2) @(posedge clk);
    `CHK(pin_oe, 1'b0)
    // Latched mode keeps a one-cycle trip until latching is switched off
    win <= 1'b0;
    wle <= 1'b1;
    @(posedge clk);
    win <= 1'b1;
    @(posedge clk);
    win <= 1'b0;
    rdr(8'h23);
    `CHK(rd[7], 1'b1)
    wle <= 1'b0;
    rdr(8'h23);
    `CHK(rd[7], 1'b0)
    cmp <= 1'b0;
    repeat (5) @(posedge clk);
    rdr(8'h23);
    `CHK(rd[3], 1'b0)
    pact <= 1'b1;
    rdr(8'h23);
    pact <= 1'b0;
    rdr(8'h23);
    `CHK(rd[8], 1'b1)
    rdr(8'h23);
    `CHK(rd[8], 1'b0)
    wr(8'h24, 16'h0004);
    drive(1'b0, 10);
    `CHK(s_f, 1'b0)
    drive(1'b1, 4);
    for (int g = 0; g < 2; g++) begin
      wr(8'h24, {g[0], 15'h0005});
      repeat (8) @(posedge clk);
      // One-cycle low pulse: shorter than the two-sample filter, seen when unfiltered
      drive(1'b0, 0);
      drive(1'b1, 10);
      `CHK(s_f, !g[0])
    end
    foreach (codes[i]) begin
      csel = 4'($urandom);
      filt = 1'($urandom);
      m = {csel[0], csel[3], csel[2]};
      wr(8'h24, {filt, 6'h00, csel, codes[i], 1'b1});
      repeat (8) @(posedge clk);
      for (int f = 1; f >= 0; f--) begin
        drive(f == 0, 10);
        e = expect_obs(codes[i], m, f[0]);
        `CHK(obs & e[43:22], e[21:0])
        if (codes[i] == 4'h5 && f == 1) begin
          rdr(8'h23);
          `CHK(rd[8], 1'b1)
        end
      end
      if (codes[i] == 4'hB) begin
        rdr(8'h24);
        `CHK(rd, 16'h0000)
      end
    end
    // Clock enable low freezes the pin path, so the edge only acts once it returns
    wr(8'h24, 16'h0005);
    repeat (4) @(posedge clk);
    ce <= 1'b0;
    drive(1'b0, 10);
    `CHK(s_f, 1'b0)
    ce <= 1'b1;
    repeat (10) @(posedge clk);
    `CHK(s_f, 1'b1)
    drive(1'b1, 4);
    results();
  end
endmodule
